//--- osdm_pkg.sv
package osdm_pkg;
    // ************************************************************
    // command opcodes
    // ************************************************************
    localparam logic [7:0] OP_POPUP = 8'h33;     // popup_compose_mode entry
    localparam logic [7:0] OP_ROW_SEL = 8'ha1;   // physical_row_select
    localparam logic [7:0] OP_CURSOR = 8'ha2;    // cursor set
    localparam logic [7:0] OP_ATTR = 8'ha3;      // attribute / colour code
    localparam logic [7:0] OP_MAP = 8'ha4;       // write row map
    localparam logic [7:0] OP_CHAR = 8'ha5;      // write character
    // ************************************************************
    // map byte fields
    // ************************************************************
    localparam int MAP_ROW_LSB = 0;              // display row bits 3:0
    localparam int MAP_EN_BIT = 4;               // enable flag
    localparam int MAP_DBL_BIT = 5;              // double-height flag
    // ************************************************************
    // sizes and reset values
    // ************************************************************
    localparam int NUM_ROWS = 16;                // physical rows
    localparam int NUM_COLS = 32;                // characters per row
    localparam logic [7:0] CHAR_BLANK = 8'h20;   // erased character
    localparam logic [5:0] MAP_RESET = 6'h00;    // row map after clear
    localparam logic [7:0] HPOS_RESET = 8'h00;   // horizontal offset reset
    localparam logic [7:0] ATTR_GREEN = 8'h02;   // green character attribute
    // ************************************************************
    // horizontal timing: 63.556 us line at 250 MHz, 3% window
    // ************************************************************
    localparam int LINE_NS = 63556;                           // nominal line period
    localparam int CLK_NS = 4;                                // clock period
    localparam int LINE_CYC = LINE_NS / CLK_NS;               // nominal cycles
    localparam int TOL_CYC = (LINE_CYC * 3) / 100;            // 3 percent
    localparam logic [15:0] LINE_MIN = 16'((LINE_CYC - TOL_CYC));
    localparam logic [15:0] LINE_MAX = 16'((LINE_CYC + TOL_CYC));
    localparam logic [2:0] LOCK_COUNT = 3'h4;                 // good lines counted before lock
endpackage

//--- osdm_if.sv
`timescale 1ns/1ps
interface osdm_if;
    // ************************************************************
    // command byte link, host to decoder
    // ************************************************************
    logic cmd_valid;     // byte present
    logic [7:0] cmd_byte; // command or data byte
    logic cmd_ready;     // decoder takes byte
    logic cmd_first;     // host marks opcode byte
    modport device (input cmd_valid, input cmd_byte, input cmd_first, output cmd_ready);
    modport host (output cmd_valid, output cmd_byte, output cmd_first, input cmd_ready);
endinterface

//--- osdm_host.sv
`timescale 1ns/1ps
module osdm_host (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_two,
    input wire logic [7:0] req_op,
    input wire logic [7:0] req_data,
    input wire logic in_popup,
    output logic req_ready,
    output logic req_refused,
    osdm_if.host link
);
    // ************************************************************
    // sender state
    // ************************************************************
    typedef enum logic [1:0] {HS_IDLE, HS_OP, HS_DATA} osdm_hs_e;
    osdm_hs_e state_r;
    logic [7:0] op_r;      // held opcode
    logic [7:0] data_r;    // held data byte
    logic two_r;           // two-byte command
    logic manual;          // row control opcode
    logic refused_r;       // refusal pulse

    assign manual = req_op != osdm_pkg::OP_POPUP;
    assign req_ready = state_r == HS_IDLE;
    assign req_refused = refused_r;
    // ************************************************************
    // link drive
    // ************************************************************
    assign link.cmd_valid = state_r != HS_IDLE;
    assign link.cmd_byte = (state_r == HS_DATA) ? data_r : op_r;
    assign link.cmd_first = state_r == HS_OP;

    // sequencing of opcode then data
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= HS_IDLE;
            op_r <= 8'h00;
            data_r <= 8'h00;
            two_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            refused_r <= 1'b0;
            case (state_r)
                HS_IDLE: begin
                    if (req_valid && manual && !in_popup) begin
                        refused_r <= 1'b1;
                    end else if (req_valid) begin
                        op_r <= req_op;
                        data_r <= req_data;
                        two_r <= req_two;
                        state_r <= HS_OP;
                    end
                end
                HS_OP: begin
                    if (link.cmd_ready) begin
                        state_r <= two_r ? HS_DATA : HS_IDLE;
                    end
                end
                HS_DATA: begin
                    if (link.cmd_ready) begin
                        state_r <= HS_IDLE;
                    end
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end
endmodule // osdm_host

//--- osdm_device.sv
`timescale 1ns/1ps
// What this block does
// - opcode 33 enters popup compose mode
// - A1 data selects the physical row
// - map 31: display row 1, enabled, double
// - map 16: display row 6, enabled, single
// - map 00 disables selected row only
// - A2 sets cursor, A3 sets attribute
// - caption line decoded in both fields
// - split caption and extended data service
// - host supplies vertical timing without video
// - either horizontal polarity, lock within 3%
// - external lock uses receiver flyback pulse
// - display offset by horizontal timing value
// - popup entry clears maps and memory
// - sixteen rows, map sets row, height, enable
// - row commands only in popup mode
module osdm_device (
    input wire logic clk,
    input wire logic reset,
    osdm_if.device link,
    input wire logic line_valid,
    input wire logic line_field,
    input wire logic [7:0] line_byte,
    input wire logic line_is_xds,
    input wire logic [1:0] chan_sel,
    input wire logic [1:0] line_chan,
    input wire logic horizontal_timing_input,
    input wire logic h_invert,
    input wire logic external_horizontal_lock,
    input wire logic vertical_timing_input,
    input wire logic video_present,
    input wire logic [7:0] hpos_value,
    input wire logic [3:0] rd_row,
    input wire logic [4:0] rd_col,
    output logic popup_compose_mode,
    output logic busy,
    output logic [5:0] map_out [osdm_pkg::NUM_ROWS],
    output logic [7:0] rd_char,
    output logic [7:0] cursor_out,
    output logic [7:0] attr_out,
    output logic [3:0] sel_row_out,
    output logic cap_valid,
    output logic [7:0] cap_byte,
    output logic cap_field,
    output logic xds_valid,
    output logic [7:0] xds_byte,
    output logic xds_field,
    output logic h_locked,
    output logic [7:0] h_offset,
    output logic v_sync
);
    // ************************************************************
    // command decoder state
    // ************************************************************
    typedef enum logic [1:0] {DS_OP, DS_DATA, DS_CLEAR} osdm_ds_e;
    osdm_ds_e state_r;
    logic [7:0] op_r;                         // pending opcode
    logic [3:0] sel_row_r;                    // selected physical row
    logic [7:0] cursor_r;                     // cursor position
    logic [7:0] attr_r;                       // current attribute
    logic popup_r;                            // compose mode flag
    logic [3:0] clr_row_r;                    // erase sweep row
    logic [5:0] map_r [osdm_pkg::NUM_ROWS];   // row maps
    logic [7:0] mem_r [osdm_pkg::NUM_ROWS][osdm_pkg::NUM_COLS]; // character memory
    logic take;                               // byte accepted
    logic [4:0] col;                          // write column

    assign link.cmd_ready = state_r != DS_CLEAR;
    assign take = link.cmd_valid && link.cmd_ready;
    assign busy = state_r == DS_CLEAR;
    assign popup_compose_mode = popup_r;
    assign sel_row_out = sel_row_r;
    assign cursor_out = cursor_r;
    assign attr_out = attr_r;
    assign map_out = map_r;
    assign col = cursor_r[4:0];

    // opcode / data sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= DS_OP;
            op_r <= 8'h00;
            popup_r <= 1'b0;
            clr_row_r <= 4'h0;
        end else begin
            case (state_r)
                DS_OP: begin
                    if (take && link.cmd_byte == osdm_pkg::OP_POPUP) begin
                        popup_r <= 1'b1;
                        clr_row_r <= 4'h0;
                        state_r <= DS_CLEAR;
                    end else if (take) begin
                        op_r <= link.cmd_byte;
                        state_r <= DS_DATA;
                    end
                end
                DS_DATA: begin
                    if (take) begin
                        state_r <= DS_OP;
                    end
                end
                DS_CLEAR: begin
                    // one row per cycle, input stalled meanwhile
                    clr_row_r <= clr_row_r + 4'h1;
                    if (clr_row_r == 4'hf) begin
                        state_r <= DS_OP;
                    end
                end
                default: state_r <= DS_OP;
            endcase
        end
    end

    // row select, cursor and attribute
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_row_r <= 4'h0;
            cursor_r <= 8'h00;
            attr_r <= 8'h00;
        end else if (state_r == DS_DATA && take) begin
            case (op_r)
                osdm_pkg::OP_ROW_SEL: sel_row_r <= link.cmd_byte[3:0];
                osdm_pkg::OP_CURSOR: cursor_r <= link.cmd_byte;
                osdm_pkg::OP_ATTR: attr_r <= link.cmd_byte;
                osdm_pkg::OP_CHAR: cursor_r <= cursor_r + 8'h01;
                default: cursor_r <= cursor_r;
            endcase
        end
    end

    // row map table
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < osdm_pkg::NUM_ROWS; i++) begin
                map_r[i] <= osdm_pkg::MAP_RESET;
            end
        end else if (state_r == DS_CLEAR) begin
            map_r[clr_row_r] <= osdm_pkg::MAP_RESET;
        end else if (state_r == DS_DATA && take && op_r == osdm_pkg::OP_MAP && popup_r) begin
            // fields: row 3:0, enable 4, double 5; only selected row touched
            map_r[sel_row_r] <= link.cmd_byte[osdm_pkg::MAP_DBL_BIT:osdm_pkg::MAP_ROW_LSB];
        end
    end

    // character memory, written at the cursor column of the selected row
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int r = 0; r < osdm_pkg::NUM_ROWS; r++) begin
                for (int c = 0; c < osdm_pkg::NUM_COLS; c++) begin
                    mem_r[r][c] <= osdm_pkg::CHAR_BLANK;
                end
            end
        end else if (state_r == DS_CLEAR) begin
            for (int c = 0; c < osdm_pkg::NUM_COLS; c++) begin
                mem_r[clr_row_r][c] <= osdm_pkg::CHAR_BLANK;
            end
        end else if (state_r == DS_DATA && take && op_r == osdm_pkg::OP_CHAR) begin
            mem_r[sel_row_r][col] <= link.cmd_byte;
        end
    end

    // display read port
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_char <= 8'h00;
        end else begin
            rd_char <= mem_r[rd_row][rd_col];
        end
    end

    // ************************************************************
    // line data split, both fields
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_valid <= 1'b0;
            xds_valid <= 1'b0;
            cap_byte <= 8'h00;
            xds_byte <= 8'h00;
            cap_field <= 1'b0;
            xds_field <= 1'b0;
        end else begin
            // fields 1 and 2 handled alike
            cap_valid <= line_valid && !line_is_xds && line_chan == chan_sel;
            xds_valid <= line_valid && line_is_xds;
            if (line_valid && !line_is_xds) begin
                cap_byte <= line_byte;
                cap_field <= line_field;
            end
            if (line_valid && line_is_xds) begin
                xds_byte <= line_byte;
                xds_field <= line_field;
            end
        end
    end

    // ************************************************************
    // horizontal timing lock
    // ************************************************************
    logic h_prev_r;        // polarity-corrected, previous
    logic h_now;           // polarity-corrected input
    logic [15:0] hcnt_r;   // cycles since last edge
    logic [2:0] good_r;    // consecutive good lines
    assign h_now = horizontal_timing_input ^ h_invert;

    // period measure; flyback pulse in external lock mode
    always_ff @(posedge clk) begin
        if (reset) begin
            h_prev_r <= 1'b0;
            hcnt_r <= 16'h0000;
            good_r <= 3'h0;
            h_locked <= 1'b0;
        end else begin
            h_prev_r <= h_now;
            if (h_now && !h_prev_r) begin
                hcnt_r <= 16'h0000;
                if (hcnt_r >= osdm_pkg::LINE_MIN && hcnt_r <= osdm_pkg::LINE_MAX) begin
                    if (good_r != osdm_pkg::LOCK_COUNT) begin
                        good_r <= good_r + 3'h1;
                    end
                    h_locked <= good_r == osdm_pkg::LOCK_COUNT || external_horizontal_lock;
                end else begin
                    good_r <= 3'h0;
                    h_locked <= 1'b0;
                end
            end else if (hcnt_r != 16'hffff) begin
                hcnt_r <= hcnt_r + 16'h0001;
            end
        end
    end

    // display offset and vertical source
    always_ff @(posedge clk) begin
        if (reset) begin
            h_offset <= osdm_pkg::HPOS_RESET;
            v_sync <= 1'b0;
        end else begin
            h_offset <= hpos_value;
            v_sync <= video_present ? 1'b0 : vertical_timing_input;
        end
    end
endmodule // osdm_device

//--- osdm_sva.sv
`timescale 1ns/1ps
module osdm_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_ready,
    input wire logic cmd_first
);
    // ****************************************
    // helper state
    // ****************************************
    logic popup_seen_r; // compose entry seen since reset
    wire logic take = cmd_valid && cmd_ready; // byte accepted this edge
    wire logic pop_take = take && cmd_first && cmd_byte == osdm_pkg::OP_POPUP; // compose entry taken
    // remember compose entry
    always_ff @(posedge clk) begin
        if (reset) begin
            popup_seen_r <= 1'b0;
        end else if (pop_take) begin
            popup_seen_r <= 1'b1;
        end
    end
    // ****************************************
    // link assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // opcode must be followed by its data byte
    property two_byte(logic [7:0] op);
        take && cmd_first && cmd_byte == op |=> ##[0:3] (cmd_valid && !cmd_first);
    endproperty
    hold_byte_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
        else $error("command byte changed before acceptance");
    valid_drop_a: assert property ($fell(cmd_valid) |-> $past(cmd_ready))
        else $error("command byte withdrawn without acceptance");
    popup_alone_a: assert property (pop_take |=> !(cmd_valid && !cmd_first) [*3])
        else $error("data byte sent after compose entry");
    popup_stall_a: assert property (pop_take |=> !cmd_ready [*8])
        else $error("bytes accepted while clearing");
    clear_end_a: assert property (pop_take |-> ##[9:24] cmd_ready)
        else $error("clearing did not finish in time");
    row_sel_a: assert property (two_byte(osdm_pkg::OP_ROW_SEL))
        else $error("row select without data byte");
    cursor_set_a: assert property (two_byte(osdm_pkg::OP_CURSOR))
        else $error("cursor set without data byte");
    attr_set_a: assert property (two_byte(osdm_pkg::OP_ATTR))
        else $error("attribute without data byte");
    map_write_a: assert property (two_byte(osdm_pkg::OP_MAP))
        else $error("map write without data byte");
    pair_order_a: assert property (take && !cmd_first |=> !(cmd_valid && !cmd_first))
        else $error("two data bytes in a row");
    popup_first_a: assert property (cmd_valid && cmd_first && !popup_seen_r |-> cmd_byte == osdm_pkg::OP_POPUP)
        else $error("row command sent before compose entry");
    // main scenarios
    cover property (pop_take);
    cover property (take && cmd_first && cmd_byte == osdm_pkg::OP_MAP);
    cover property (pop_take && popup_seen_r);
endmodule // osdm_sva

//--- osd_manual_row_mapping_tb_top.sv
`timescale 1ns/1ps
module osd_manual_row_mapping_tb_top;
    // ****************************************
    // signals
    // ****************************************
    logic clk, reset, req_valid, req_two, req_ready, req_refused, refused_seen; // host side
    logic line_valid, line_field, line_is_xds, hti, h_inv, ext_lock, vti, video_present; // device inputs
    logic popup, busy, cap_valid, cap_field, xds_valid, xds_field, h_locked, v_sync; // device outputs
    logic [7:0] req_op, req_data, line_byte, hpos_value, rd_char, cursor_out, attr_out, cap_byte, xds_byte, h_offset;
    logic [1:0] chan_sel, line_chan; // selected channel, channel of the line
    logic [3:0] rd_row, sel_row; // read row, selected row
    logic [4:0] rd_col; // read column
    logic [5:0] map_out [osdm_pkg::NUM_ROWS]; // row maps
    int errors, n_compared; // counters
    // ****************************************
    // design and checker
    // ****************************************
    osdm_if link();
    osdm_host osdm_host_inst (.clk(clk), .reset(reset), .req_valid(req_valid), .req_two(req_two), .req_op(req_op),
        .req_data(req_data), .in_popup(popup), .req_ready(req_ready), .req_refused(req_refused), .link(link));
    osdm_device osdm_device_inst (.clk(clk), .reset(reset), .link(link), .line_valid(line_valid),
        .line_field(line_field), .line_byte(line_byte), .line_is_xds(line_is_xds), .chan_sel(chan_sel),
        .line_chan(line_chan), .horizontal_timing_input(hti), .h_invert(h_inv), .external_horizontal_lock(ext_lock),
        .vertical_timing_input(vti), .video_present(video_present), .hpos_value(hpos_value), .rd_row(rd_row),
        .rd_col(rd_col), .popup_compose_mode(popup), .busy(busy), .map_out(map_out), .rd_char(rd_char),
        .cursor_out(cursor_out), .attr_out(attr_out), .sel_row_out(sel_row), .cap_valid(cap_valid),
        .cap_byte(cap_byte), .cap_field(cap_field), .xds_valid(xds_valid), .xds_byte(xds_byte),
        .xds_field(xds_field), .h_locked(h_locked), .h_offset(h_offset), .v_sync(v_sync));
    osdm_sva osdm_sva_inst (.clk(clk), .reset(reset), .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte),
        .cmd_ready(link.cmd_ready), .cmd_first(link.cmd_first));
    // 250 MHz clock
    always #2 clk = ~clk;
    // ****************************************
    // tasks
    // ****************************************
    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    // one host command, waits until fully done
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic two);
        int n;
        n = 0;
        refused_seen = 1'b0;
        req_op <= op;
        req_data <= dat;
        req_two <= two;
        req_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
        end
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            refused_seen |= (req_refused === 1'b1);
        end while ((n < 3 || req_ready !== 1'b1 || busy !== 1'b0) && n < 60);
        if (n >= 60) begin
            errors++;
        end
        @(posedge clk);
    endtask
    // read back one stored character
    task automatic rd_chk(input logic [3:0] r, input logic [4:0] c, input logic [7:0] exp);
        rd_row <= r;
        rd_col <= c;
        repeat (3) @(posedge clk);
        check(rd_char, exp);
    endtask
    // one recovered line byte, expect it on the matching output
    task automatic line_in(input logic f, input logic x, input logic [7:0] b);
        int n;
        n = 0;
        line_field <= f;
        line_is_xds <= x;
        line_byte <= b;
        line_valid <= 1'b1;
        @(posedge clk);
        line_valid <= 1'b0;
        while ((x ? xds_valid : cap_valid) !== 1'b1 && n < 5) begin
            @(posedge clk);
            n++;
        end
        check({7'h0, x ? xds_valid : cap_valid}, 8'h01);
        check(x ? xds_byte : cap_byte, b);
        check({7'h0, x ? xds_field : cap_field}, {7'h0, f});
    endtask
    // low-going horizontal pulse after a gap
    task automatic h_pulse(input int gap);
        repeat (gap) @(posedge clk);
        hti <= 1'b0;
        repeat (8) @(posedge clk);
        hti <= 1'b1;
    endtask
    // verdict
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    // watchdog against hangs
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        stop_test;
    end
    initial begin
        {clk, req_valid, req_two, line_valid, line_field, line_is_xds, vti, video_present} = '0;
        {reset, hti, h_inv, ext_lock} = '1;
        {req_op, req_data, line_byte, hpos_value, rd_row, rd_col, chan_sel, line_chan} = '0;
        errors = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        cmd(osdm_pkg::OP_ROW_SEL, 8'h03, 1'b1);
        check({7'h0, refused_seen}, 8'h01);
        check({7'h0, popup}, 8'h00);
        $display("test refuse done");
        cmd(osdm_pkg::OP_POPUP, 8'h00, 1'b0);
        check({7'h0, popup}, 8'h01);
        cmd(osdm_pkg::OP_ROW_SEL, 8'h00, 1'b1);
        check({4'h0, sel_row}, 8'h00);
        cmd(osdm_pkg::OP_CURSOR, 8'h02, 1'b1);
        check(cursor_out, 8'h02);
        cmd(osdm_pkg::OP_ATTR, 8'h02, 1'b1);
        check(attr_out, osdm_pkg::ATTR_GREEN);
        cmd(osdm_pkg::OP_CHAR, 8'h41, 1'b1);
        rd_chk(4'h0, 5'h02, 8'h41);
        cmd(osdm_pkg::OP_MAP, 8'h31, 1'b1);
        check({2'h0, map_out[0]}, 8'h31);
        cmd(osdm_pkg::OP_ROW_SEL, 8'h01, 1'b1);
        cmd(osdm_pkg::OP_MAP, 8'h16, 1'b1);
        check({2'h0, map_out[1]}, 8'h16);
        check({2'h0, map_out[0]}, 8'h31);
        cmd(osdm_pkg::OP_ROW_SEL, 8'h0f, 1'b1);
        cmd(osdm_pkg::OP_MAP, 8'h1a, 1'b1);
        check({2'h0, map_out[15]}, 8'h1a);
        cmd(osdm_pkg::OP_ROW_SEL, 8'h01, 1'b1);
        cmd(osdm_pkg::OP_MAP, 8'h00, 1'b1);
        check({2'h0, map_out[1]}, 8'h00);
        check({2'h0, map_out[15]}, 8'h1a);
        $display("test rows done");
        cmd(osdm_pkg::OP_POPUP, 8'h00, 1'b0);
        check({2'h0, map_out[0]}, 8'h00);
        check({2'h0, map_out[15]}, 8'h00);
        rd_chk(4'h0, 5'h02, osdm_pkg::CHAR_BLANK);
        $display("test clear done");
        chan_sel <= 2'h1;
        line_chan <= 2'h1;
        line_in(1'b0, 1'b0, 8'h14);
        line_in(1'b1, 1'b0, 8'h2c);
        line_in(1'b1, 1'b1, 8'h05);
        // caption byte of another channel must not be passed on
        line_chan <= 2'h2;
        line_is_xds <= 1'b0;
        line_byte <= 8'h3e;
        line_valid <= 1'b1;
        @(posedge clk);
        line_valid <= 1'b0;
        @(posedge clk);
        check({7'h0, cap_valid}, 8'h00);
        $display("test lines done");
        hpos_value <= 8'h5a;
        vti <= 1'b1;
        repeat (4) @(posedge clk);
        check(h_offset, 8'h5a);
        check({7'h0, v_sync}, 8'h01);
        h_pulse(20);
        h_pulse(int'(osdm_pkg::LINE_MAX) + 32);
        repeat (4) @(posedge clk);
        check({7'h0, h_locked}, 8'h00);
        h_pulse(osdm_pkg::LINE_CYC - 8);
        repeat (4) @(posedge clk);
        check({7'h0, h_locked}, 8'h01);
        $display("test timing done");
        stop_test;
    end
endmodule // osd_manual_row_mapping_tb_top
